// file: pkg/gst_pkg.sv
package gst_pkg;

    localparam int unsigned PCLK_HZ = 50000000;
    localparam int unsigned INSTR_HZ = 12500000;
    localparam int unsigned INSTR_DIV = PCLK_HZ / INSTR_HZ;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);

    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT_LOW_BYTE = 8'h04;
    localparam logic [7:0] OFS_COUNT_HIGH_BYTE = 8'h08;
    localparam logic [7:0] OFS_GATE_CONFIG = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CONTROL = 8'h10;
    localparam logic [7:0] OFS_CC_PAIR = 8'h14;
    localparam logic [7:0] OFS_CC_CONTROL = 8'h18;

    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [15:0] ISR_VECTOR = 16'h0004;
    localparam logic [15:0] NO_VECTOR = 16'h0000;

    localparam int unsigned IRQ_FLAG_BIT = 0;
    localparam int unsigned IRQ_TIE_BIT = 1;
    localparam int unsigned IRQ_PERIPHERAL_IRQ_ENABLE_BIT = 2;
    localparam int unsigned IRQ_GIE_BIT = 3;
    localparam int unsigned CC_CAPTURE_BIT = 0;
    localparam int unsigned CC_COMPARE_BIT = 1;
    localparam int unsigned CC_SPECIAL_BIT = 2;
    localparam int unsigned CC_FLAG_BIT = 3;

    localparam int unsigned PIN_COUNT = 0;
    localparam int unsigned PIN_LPOSC = 1;
    localparam int unsigned PIN_GATE = 2;
    localparam int unsigned PIN_COMP = 3;
    localparam int unsigned PIN_NUM = 4;

    localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
    localparam logic [1:0] PRESCALE_DIV2 = 2'h1;
    localparam logic [1:0] PRESCALE_DIV4 = 2'h2;
    localparam logic [2:0] PRESCALE_LAST1 = 3'h0;
    localparam logic [2:0] PRESCALE_LAST2 = 3'h1;
    localparam logic [2:0] PRESCALE_LAST4 = 3'h3;
    localparam logic [2:0] PRESCALE_LAST8 = 3'h7;

    typedef struct packed {
        logic gate_polarity;
        logic gate_enable;
        logic [1:0] input_prescale_select;
        logic low_power_osc_enable;
        logic external_sync_disable;
        logic clock_source_select;
        logic timer_on;
    } gst_ctrl_s;

    typedef struct packed {
        logic rollover_irq;
        logic wake;
        logic compare_event;
        logic timer_clk_tick;
    } gst_event_s;

endpackage : gst_pkg

// file: src/gst_timer.sv
`timescale 1ns/1ps

module gst_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_input,
    input wire logic lp_osc_input,
    input wire logic gate_pin,
    input wire logic second_comparator_output,
    input wire logic capture_event,
    input wire logic core_sleep,
    output logic lp_osc_run,
    output logic [15:0] wake_vector,
    output gst_pkg::gst_event_s events
);
    import gst_pkg::*;

    gst_ctrl_s ctrl_q;
    logic gate_source_select_q;
    logic [15:0] count_q;
    logic [2:0] prescale_q;
    logic rollover_flag_q;
    logic rollover_irq_enable_q;
    logic peripheral_irq_enable_q;
    logic global_irq_enable_q;
    logic [15:0] cc_pair_q;
    logic capture_mode_q;
    logic compare_mode_q;
    logic special_enable_q;
    logic compare_flag_q;
    logic match_q;
    logic [1:0] instr_div_q;
    logic timer_on_q;
    logic fell_seen_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic lp_osc_run_q;
    logic [15:0] wake_vector_q;
    gst_event_s events_q;

    logic [PIN_NUM-1:0] pin_raw;
    logic [PIN_NUM-1:0] pin_lvl_q;
    logic [PIN_NUM-1:0] pin_prev_q;

    assign pin_raw[PIN_COUNT] = external_count_input;
    assign pin_raw[PIN_LPOSC] = lp_osc_input;
    assign pin_raw[PIN_GATE] = gate_pin;
    assign pin_raw[PIN_COMP] = second_comparator_output;

    // Each pin is caught by three flops; a level is accepted once the last two agree.
    genvar gi;
    generate
        for (gi = 0; gi < PIN_NUM; gi++) begin : g_pin
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    pin_lvl_q[gi] <= 1'b0;
                    pin_prev_q[gi] <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        pin_lvl_q[gi] <= s3_q;
                    end
                    pin_prev_q[gi] <= pin_lvl_q[gi];
                end
            end
        end
    endgenerate

    logic apb_setup;
    logic apb_done;
    logic wr_done;
    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic wr_cnt;
    logic addr_ok;
    assign apb_setup = psel && penable && !pready_q;
    assign apb_done = psel && penable && pready_q;
    assign wr_done = apb_done && pwrite && !pslverr_q;
    assign wr_ctrl = wr_done && (paddr == OFS_TIMER_CONTROL);
    assign wr_low = wr_done && (paddr == OFS_COUNT_LOW_BYTE);
    assign wr_high = wr_done && (paddr == OFS_COUNT_HIGH_BYTE);
    assign wr_cnt = wr_low || wr_high;
    assign addr_ok = (paddr == OFS_TIMER_CONTROL) || (paddr == OFS_COUNT_LOW_BYTE) ||
                     (paddr == OFS_COUNT_HIGH_BYTE) || (paddr == OFS_GATE_CONFIG) ||
                     (paddr == OFS_IRQ_CONTROL) || (paddr == OFS_CC_PAIR) || (paddr == OFS_CC_CONTROL);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_TIMER_CONTROL: rd_mux[7:0] = ctrl_q;
            OFS_COUNT_LOW_BYTE: rd_mux[7:0] = count_q[7:0];
            OFS_COUNT_HIGH_BYTE: rd_mux[7:0] = count_q[15:8];
            OFS_GATE_CONFIG: rd_mux[0] = gate_source_select_q;
            OFS_IRQ_CONTROL: rd_mux[3:0] = {global_irq_enable_q, peripheral_irq_enable_q,
                                            rollover_irq_enable_q, rollover_flag_q};
            OFS_CC_PAIR: rd_mux[15:0] = cc_pair_q;
            OFS_CC_CONTROL: rd_mux[3:0] = {compare_flag_q, special_enable_q, compare_mode_q, capture_mode_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Every access holds one wait state; the answer is latched with pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && !addr_ok;
            if (apb_setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= TIMER_CONTROL_RESET;
            gate_source_select_q <= 1'b0;
            rollover_irq_enable_q <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
            global_irq_enable_q <= 1'b0;
            capture_mode_q <= 1'b0;
            compare_mode_q <= 1'b0;
            special_enable_q <= 1'b0;
        end else if (wr_done) begin
            case (paddr)
                OFS_TIMER_CONTROL: ctrl_q <= pwdata[7:0];
                OFS_GATE_CONFIG: gate_source_select_q <= pwdata[0];
                OFS_IRQ_CONTROL: begin
                    rollover_irq_enable_q <= pwdata[IRQ_TIE_BIT];
                    peripheral_irq_enable_q <= pwdata[IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
                    global_irq_enable_q <= pwdata[IRQ_GIE_BIT];
                end
                OFS_CC_CONTROL: begin
                    capture_mode_q <= pwdata[CC_CAPTURE_BIT];
                    compare_mode_q <= pwdata[CC_COMPARE_BIT];
                    special_enable_q <= pwdata[CC_SPECIAL_BIT];
                end
                default: ;
            endcase
        end
    end

    // Instruction clock enable at a quarter of pclk.
    logic instr_tick;
    assign instr_tick = (instr_div_q == INSTR_DIV_LAST);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_div_q <= 2'h0;
        end else begin
            instr_div_q <= 2'(instr_div_q + 2'h1);
        end
    end

    logic ext_lvl;
    logic ext_prev;
    logic ext_rise;
    logic ext_fall;
    assign ext_lvl = ctrl_q.low_power_osc_enable ? pin_lvl_q[PIN_LPOSC] : pin_lvl_q[PIN_COUNT];
    assign ext_prev = ctrl_q.low_power_osc_enable ? pin_prev_q[PIN_LPOSC] : pin_prev_q[PIN_COUNT];
    assign ext_rise = ext_lvl && !ext_prev;
    assign ext_fall = !ext_lvl && ext_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_on_q <= 1'b0;
            fell_seen_q <= 1'b0;
        end else begin
            timer_on_q <= ctrl_q.timer_on;
            if (wr_cnt || (ctrl_q.timer_on && !timer_on_q)) begin
                fell_seen_q <= 1'b0;
            end else if (ext_fall) begin
                fell_seen_q <= 1'b1;
            end
        end
    end

    logic async_mode;
    logic awake_ok;
    logic src_tick;
    logic gate_raw;
    logic gate_active;
    logic run;
    logic [2:0] prescale_last;
    logic pre_tick;
    logic inc;
    assign async_mode = ctrl_q.clock_source_select && ctrl_q.external_sync_disable;
    assign awake_ok = !core_sleep || async_mode;
    assign src_tick = ctrl_q.clock_source_select ? (ext_rise && fell_seen_q) : instr_tick;
    assign gate_raw = gate_source_select_q ? pin_lvl_q[PIN_COMP] : pin_lvl_q[PIN_GATE];
    assign gate_active = ctrl_q.gate_polarity ? gate_raw : !gate_raw;
    assign run = ctrl_q.timer_on && (!ctrl_q.gate_enable || gate_active) && awake_ok;

    always_comb begin
        case (ctrl_q.input_prescale_select)
            PRESCALE_DIV1: prescale_last = PRESCALE_LAST1;
            PRESCALE_DIV2: prescale_last = PRESCALE_LAST2;
            PRESCALE_DIV4: prescale_last = PRESCALE_LAST4;
            default: prescale_last = PRESCALE_LAST8;
        endcase
    end
    assign pre_tick = run && src_tick && (prescale_q >= prescale_last);
    assign inc = pre_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_q <= 3'h0;
        end else if (wr_cnt) begin
            prescale_q <= 3'h0;
        end else if (run && src_tick) begin
            prescale_q <= pre_tick ? 3'h0 : 3'(prescale_q + 3'h1);
        end
    end

    logic match;
    logic match_rise;
    logic special_clear;
    logic wrap;
    assign match = compare_mode_q && (count_q == cc_pair_q);
    assign match_rise = match && !match_q;
    assign special_clear = match_rise && special_enable_q;
    assign wrap = inc && (count_q == COUNT_MAX) && !special_clear;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= COUNT_ZERO;
        end else if (wr_cnt) begin
            if (wr_low) begin
                count_q[7:0] <= pwdata[7:0];
            end else begin
                count_q[15:8] <= pwdata[7:0];
            end
        end else if (special_clear) begin
            count_q <= COUNT_ZERO;
        end else if (inc) begin
            count_q <= 16'(count_q + COUNT_STEP);
        end
    end

    logic flag_clear;
    logic cflag_clear;
    assign flag_clear = wr_done && (paddr == OFS_IRQ_CONTROL) && !pwdata[IRQ_FLAG_BIT];
    assign cflag_clear = wr_done && (paddr == OFS_CC_CONTROL) && !pwdata[CC_FLAG_BIT];

    // A flag being set in the same cycle as a software clear stays set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rollover_flag_q <= 1'b0;
            compare_flag_q <= 1'b0;
            match_q <= 1'b0;
        end else begin
            match_q <= match;
            if (wrap && !wr_cnt) begin
                rollover_flag_q <= 1'b1;
            end else if (flag_clear) begin
                rollover_flag_q <= 1'b0;
            end
            if (match_rise) begin
                compare_flag_q <= 1'b1;
            end else if (cflag_clear) begin
                compare_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_pair_q <= COUNT_ZERO;
        end else if (capture_mode_q && capture_event) begin
            cc_pair_q <= count_q;
        end else if (wr_done && (paddr == OFS_CC_PAIR)) begin
            cc_pair_q <= pwdata[15:0];
        end
    end

    logic irq_d;
    logic wake_d;
    assign irq_d = rollover_flag_q && rollover_irq_enable_q && peripheral_irq_enable_q && global_irq_enable_q;
    assign wake_d = core_sleep && ctrl_q.timer_on && rollover_flag_q && rollover_irq_enable_q &&
                    peripheral_irq_enable_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events_q <= '0;
            lp_osc_run_q <= 1'b0;
            wake_vector_q <= NO_VECTOR;
        end else begin
            events_q.rollover_irq <= irq_d;
            events_q.wake <= wake_d;
            events_q.compare_event <= match_rise;
            events_q.timer_clk_tick <= run && src_tick;
            lp_osc_run_q <= ctrl_q.low_power_osc_enable;
            wake_vector_q <= global_irq_enable_q ? ISR_VECTOR : NO_VECTOR;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign lp_osc_run = lp_osc_run_q;
    assign wake_vector = wake_vector_q;
    assign events = events_q;

    a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        wrap && !wr_cnt |=> rollover_flag_q && (count_q == COUNT_ZERO))
        else $error("Wrap did not zero the counter and set the flag.");

    a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
        rollover_flag_q && !flag_clear |=> rollover_flag_q)
        else $error("Rollover flag dropped without a clear.");

    a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
        events_q.rollover_irq |-> $past(rollover_flag_q) && $past(global_irq_enable_q) &&
            $past(peripheral_irq_enable_q) && $past(rollover_irq_enable_q))
        else $error("Interrupt raised without every enable set.");

    a_off_no_count: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q.timer_on && !wr_cnt && !special_clear |=> $stable(count_q))
        else $error("Counter moved while stopped.");

    a_sleep_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        core_sleep && !async_mode && !wr_cnt && !special_clear |=> $stable(count_q))
        else $error("Counter advanced in sleep outside asynchronous mode.");

    a_special_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
        special_clear && !wr_cnt && !rollover_flag_q |=> (count_q == COUNT_ZERO) && !rollover_flag_q)
        else $error("Special clear failed or set the rollover flag.");

    a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
        wr_low |=> count_q[7:0] == $past(pwdata[7:0]))
        else $error("Counter byte write lost.");

    a_prescale_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cnt |=> prescale_q == 3'h0)
        else $error("Prescaler not cleared by counter write.");

    a_gate_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.gate_enable && !gate_active |-> !inc)
        else $error("Counter ticked with the gate closed.");

    a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
        capture_mode_q && capture_event |=> cc_pair_q == $past(count_q))
        else $error("Capture did not copy the counter.");

    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("Bus answer not after exactly one wait state.");

endmodule : gst_timer

// file: verif/gst_src_model.sv
`timescale 1ns/1ps
module gst_src_model (
    input wire logic pclk,
    output logic count_pin,
    output logic osc_pin
);
    initial begin
        count_pin = 1'b1;
        osc_pin = 1'b1;
    end

    // Each level is held eight cycles so that the pin synchroniser sees every edge.
    task automatic edges(input int n, input bit osc);
        repeat (n) begin
            repeat (8) @(posedge pclk);
            if (osc) begin
                osc_pin <= ~osc_pin;
            end else begin
                count_pin <= ~count_pin;
            end
        end
        repeat (8) @(posedge pclk);
    endtask : edges
endmodule : gst_src_model

// file: verif/gst_timer_tb_top.sv
`timescale 1ns/1ps
module gst_timer_tb_top;
    import gst_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic count_pin, osc_pin, gate_pin, comp_out, cap_evt, sleep, lp_osc_run;
    logic [15:0] wake_vector, c;
    gst_event_s ev;
    int n_mismatch = 0;
    int cmp_count = 0;
    int ticks = 0;
    int hits = 0;
    int t0;

    gst_timer i_gst_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_input(count_pin), .lp_osc_input(osc_pin),
        .gate_pin(gate_pin), .second_comparator_output(comp_out), .capture_event(cap_evt),
        .core_sleep(sleep), .lp_osc_run(lp_osc_run), .wake_vector(wake_vector), .events(ev));
    gst_src_model i_gst_src_model (.pclk(pclk), .count_pin(count_pin), .osc_pin(osc_pin));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (ev.timer_clk_tick === 1'b1) ticks <= ticks + 1;
        if (ev.compare_event === 1'b1) hits <= hits + 1;
    end

    task automatic stop_test;
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic chk1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : chk1

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic set_count(input logic [15:0] v);
        apb(1'b1, OFS_COUNT_LOW_BYTE, {24'h0, v[7:0]});
        apb(1'b1, OFS_COUNT_HIGH_BYTE, {24'h0, v[15:8]});
    endtask : set_count

    task automatic get_count;
        apb(1'b0, OFS_COUNT_LOW_BYTE, 32'h0);
        c[7:0] = rd[7:0];
        apb(1'b0, OFS_COUNT_HIGH_BYTE, 32'h0);
        c[15:8] = rd[7:0];
    endtask : get_count

    task automatic run(input logic [7:0] ctl, input int n);
        set_count(16'h0);
        apb(1'b1, OFS_TIMER_CONTROL, {24'h0, ctl});
        cyc(n);
        apb(1'b1, OFS_TIMER_CONTROL, {24'h0, ctl & 8'hfe});
        get_count();
    endtask : run

    // The count is widened to a signed four-state word so that an expected zero compares correctly.
    function automatic logic near(input logic [15:0] s, input int e);
        logic signed [31:0] v;
        v = {16'h0, s};
        return (v >= e - 1) && (v <= e + 1);
    endfunction : near

    task automatic gate_case(input logic src, pin, cmp, input logic [7:0] ctl, input int e);
        gate_pin <= pin;
        comp_out <= cmp;
        apb(1'b1, OFS_GATE_CONFIG, {31'h0, src});
        run(ctl, 476);
        chk1(near(c, e), 1'b1);
    endtask : gate_case

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        gate_pin = 1'b0;
        comp_out = 1'b0;
        cap_evt = 1'b0;
        sleep = 1'b0;
        cyc(6);
        presetn <= 1'b1;
        apb(1'b0, OFS_TIMER_CONTROL, 32'h0);
        chk(rd, {24'h0, TIMER_CONTROL_RESET});
        apb(1'b0, 8'h40, 32'h0);
        chk1(last_err, 1'b1);
        for (int p = 0; p < 4; p++) begin
            t0 = ticks;
            run({2'b00, 2'(p), 4'h1}, 476);
            chk1(near(c, 120 >> p), 1'b1);
            chk1(near(16'(ticks - t0), 120), 1'b1);
        end
        run(8'h05, 476);
        chk1(near(c, 120), 1'b1);
        gate_case(1'b0, 1'b0, 1'b1, 8'hc1, 0);
        gate_case(1'b0, 1'b1, 1'b0, 8'hc1, 120);
        gate_case(1'b0, 1'b1, 1'b0, 8'h41, 0);
        gate_case(1'b1, 1'b1, 1'b0, 8'hc1, 0);
        gate_case(1'b1, 1'b0, 1'b1, 8'hc1, 120);
        gate_case(1'b0, 1'b0, 1'b0, 8'h01, 120);
        sleep <= 1'b1;
        run(8'h01, 476);
        chk(c, 32'h0);
        set_count(16'h0);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h07);
        i_gst_src_model.edges(10, 1'b0);
        get_count();
        chk(c, 32'h5);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h06);
        sleep <= 1'b0;
        i_gst_src_model.edges(1, 1'b0);
        set_count(16'h0);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h03);
        i_gst_src_model.edges(10, 1'b0);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h02);
        get_count();
        chk(c, 32'h4);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h08);
        cyc(3);
        chk1(lp_osc_run, 1'b1);
        set_count(16'h0);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h0b);
        i_gst_src_model.edges(10, 1'b1);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h00);
        get_count();
        chk(c, 32'h5);
        chk1(lp_osc_run, 1'b0);
        apb(1'b1, OFS_IRQ_CONTROL, 32'h0e);
        set_count(16'hfffd);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h01);
        cyc(40);
        apb(1'b1, OFS_TIMER_CONTROL, 32'h00);
        get_count();
        chk1(near(c, 8), 1'b1);
        apb(1'b0, OFS_IRQ_CONTROL, 32'h0);
        chk1(rd[0], 1'b1);
        chk1(ev.rollover_irq, 1'b1);
        chk(wake_vector, ISR_VECTOR);
        sleep <= 1'b1;
        apb(1'b1, OFS_TIMER_CONTROL, 32'h01);
        cyc(3);
        chk1(ev.wake, 1'b1);
        apb(1'b1, OFS_IRQ_CONTROL, 32'h07);
        cyc(3);
        chk1(ev.rollover_irq, 1'b0);
        chk(wake_vector, NO_VECTOR);
        chk1(ev.wake, 1'b1);
        apb(1'b1, OFS_IRQ_CONTROL, 32'h06);
        cyc(3);
        chk1(ev.wake, 1'b0);
        sleep <= 1'b0;
        apb(1'b1, OFS_CC_PAIR, 32'h10);
        apb(1'b1, OFS_CC_CONTROL, 32'h06);
        t0 = hits;
        run(8'h01, 476);
        chk1(c <= 16'h10, 1'b1);
        chk1(hits - t0 >= 5, 1'b1);
        apb(1'b0, OFS_IRQ_CONTROL, 32'h0);
        chk1(rd[0], 1'b0);
        apb(1'b0, OFS_CC_CONTROL, 32'h0);
        chk1(rd[3], 1'b1);
        apb(1'b1, OFS_CC_CONTROL, 32'h01);
        set_count(16'h1234);
        cap_evt <= 1'b1;
        @(posedge pclk);
        cap_evt <= 1'b0;
        apb(1'b0, OFS_CC_PAIR, 32'h0);
        chk(rd[15:0], 32'h1234);
        stop_test();
    end

    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
endmodule : gst_timer_tb_top
